// ===== hw/dep_buffer2.sv
// Two-entry buffer; head entry and both handshake flags come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module dep_buffer2 #(
  parameter int W = 34
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  dep_stream_if.buffer s
);
  import dep_pkg::*;

  initial
  begin
    if (W < 1)
      $error("dep_buffer2: W must be at least 1");
  end

  logic [1:0] cnt_q, cnt_d;
  logic [W-1:0] d_q [2];
  logic [W-1:0] d_d [2];
  logic in_ready_q, in_ready_d;
  logic out_valid_q, out_valid_d;
  logic push, pop;
  logic [1:0] wpos;

  assign push = s.in_valid & in_ready_q;
  assign pop = out_valid_q & s.out_ready;

  always_comb
  begin
    d_d = d_q;
    wpos = cnt_q - {1'b0, pop};
    if (pop)
      d_d[0] = d_q[1];
    if (push)
      d_d[wpos[0]] = s.in_data;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    // Ready is registered so the source never sees a combinational path
    out_valid_d = (cnt_d != 2'h0);
    in_ready_d = (cnt_d != 2'h2);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q <= 2'h0;
      d_q[0] <= '0;
      d_q[1] <= '0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end
    else if (i_ce)
    begin
      cnt_q <= cnt_d;
      d_q <= d_d;
      in_ready_q <= in_ready_d;
      out_valid_q <= out_valid_d;
    end
  end

  assign s.in_ready = in_ready_q;
  assign s.out_valid = out_valid_q;
  assign s.out_data = d_q[0];
endmodule
`default_nettype wire

// ===== hw/dep_event_port.sv
// DMA-synchronised data port of the turbo-decoder coprocessor
//
// What this block does
// - Pulse transmit event (line 31) whenever the next host write transfer can start.
// - Pulse receive event (line 30) whenever results are ready for reading.
// - Final transmit event follows the decision readout, or the output parameter readout when its flag is set.
// - Interleaver transfer happens only when the new-table flag is set.
// - Decision read always happens; output parameter read only with its flag.
`timescale 1ns/1ps
`default_nettype none
module dep_event_port #(
  parameter int DATA_W = 32
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_dma_wr,
  input wire logic i_dma_rd,
  input wire logic [31:0] i_dma_addr,
  input wire logic [DATA_W-1:0] i_dma_wdata,
  output logic o_dma_wr_ready,
  output logic o_dma_rvalid,
  output logic [DATA_W-1:0] o_dma_rdata,
  output logic o_access_err,
  output logic o_transmit_sync_event,
  output logic o_receive_sync_event,
  output logic o_sym_valid,
  output dep_pkg::dep_kind_t o_sym_kind,
  output logic [DATA_W-1:0] o_sym_data,
  input wire logic i_sym_ready,
  output logic o_decode_start,
  input wire logic i_decode_done,
  output logic [15:0] o_core_raddr,
  output logic o_core_rsel,
  input wire logic [DATA_W-1:0] i_core_rdata,
  output logic o_new_table_flag,
  output logic o_output_param_flag
);
  import dep_pkg::*;

  initial
  begin
    if (DATA_W != 32)
      $error("dep_event_port: DATA_W must be 32");
  end

  // Word counts per standalone transfer kind; no shared-mode windows
  function automatic logic [17:0] words_for(input logic [1:0] sel, input logic [15:0] fl);
    logic [17:0] f;
    f = {2'h0, fl};
    unique case (sel)
      2'h0: words_for = (f + 18'h00001) & 18'h3FFFE;
      2'h1: words_for = ((f + 18'h00006) >> 2) << 1;
      default: words_for = ((f + 18'h0003F) >> 6) << 1;
    endcase
  endfunction

  function automatic logic hit16(input logic [31:0] a, input logic [31:0] base);
    hit16 = (a[31:16] == base[31:16]);
  endfunction

  dep_stream_if #(.W(DATA_W + 2)) strm ();

  dep_buffer2 #(.W(DATA_W + 2)) u_buf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .s(strm)
  );

  dep_state_t st_q, st_d;
  logic [17:0] cnt_q, cnt_d, target_q, target_d;
  logic [31:0] word0_q, word0_d;
  logic tx_q, tx_d, rx_q, rx_d, start_q, start_d, err_q, err_d;
  logic rd_pend_q, rd_pend_d;
  logic [1:0] rd_src_q, rd_src_d;
  logic [15:0] raddr_q, raddr_d;
  logic rsel_q, rsel_d;
  logic rvalid_q, rvalid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  dep_kind_t wkind;
  logic cfg_hit, sym_hit, itl_hit, hd_hit, outp_hit, word0_hit;
  logic wr_hit, wr_take, rd_hit, last;

  assign cfg_hit = hit16(i_dma_addr, DEP_CFG_BASE) && (i_dma_addr[15:6] == 10'h000);
  assign sym_hit = hit16(i_dma_addr, DEP_SYM_BASE);
  assign itl_hit = hit16(i_dma_addr, DEP_ITL_BASE);
  assign hd_hit = hit16(i_dma_addr, DEP_HD_BASE);
  assign outp_hit = (i_dma_addr >= DEP_OUTP_ADDR) && (i_dma_addr < DEP_OUTP_ADDR + 32'h0000_000C);
  assign word0_hit = (i_dma_addr == DEP_CFG_BASE);
  assign last = (cnt_q == target_q - 18'h00001);

  // Writes land only in the window the current phase expects
  always_comb
  begin
    wkind = DEP_KIND_CFG;
    wr_hit = 1'b0;
    if (st_q == DEP_ST_CFG)
      wr_hit = i_dma_wr & cfg_hit;
    else if (st_q == DEP_ST_SYM)
    begin
      wkind = DEP_KIND_SYM;
      wr_hit = i_dma_wr & sym_hit;
    end
    else if (st_q == DEP_ST_ITL)
    begin
      wkind = DEP_KIND_ITL;
      wr_hit = i_dma_wr & itl_hit;
    end
  end

  assign wr_take = wr_hit & strm.in_ready;
  assign strm.in_valid = wr_hit;
  assign strm.in_data = {wkind, i_dma_wdata};
  assign strm.out_ready = i_sym_ready;
  assign rd_hit = i_dma_rd & (((st_q == DEP_ST_HD) & hd_hit) | ((st_q == DEP_ST_OUTP) & outp_hit));

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    target_d = target_q;
    word0_d = word0_q;
    tx_d = 1'b0;
    rx_d = 1'b0;
    start_d = 1'b0;
    // Stalled writes and word0 reads are not errors; other wrong windows and phases are
    err_d = (i_dma_wr & ~wr_hit) | (i_dma_rd & ~rd_hit & ~word0_hit);
    unique case (st_q)
      DEP_ST_IDLE:
      begin
        tx_d = 1'b1;
        cnt_d = '0;
        target_d = DEP_CFG_WORDS;
        st_d = DEP_ST_CFG;
      end
      DEP_ST_CFG:
        if (wr_take)
        begin
          if (cnt_q == 18'h00000)
            word0_d = i_dma_wdata;
          cnt_d = cnt_q + 18'h00001;
          if (last)
          begin
            tx_d = 1'b1;
            cnt_d = '0;
            target_d = words_for(2'h0, word0_q[DEP_FL_LSB +: DEP_FL_W]);
            st_d = DEP_ST_SYM;
          end
        end
      DEP_ST_SYM:
        if (wr_take)
        begin
          cnt_d = cnt_q + 18'h00001;
          if (last)
          begin
            cnt_d = '0;
            if (word0_q[DEP_NEW_TABLE_BIT])
            begin
              tx_d = 1'b1;
              target_d = words_for(2'h1, word0_q[DEP_FL_LSB +: DEP_FL_W]);
              st_d = DEP_ST_ITL;
            end
            else
            begin
              start_d = 1'b1;
              st_d = DEP_ST_DEC;
            end
          end
        end
      DEP_ST_ITL:
        if (wr_take && last)
        begin
          cnt_d = '0;
          start_d = 1'b1;
          st_d = DEP_ST_DEC;
        end
        else if (wr_take)
          cnt_d = cnt_q + 18'h00001;
      DEP_ST_DEC:
        // Buffer must drain too, or the core could still be short of symbols
        if (i_decode_done && !strm.out_valid)
        begin
          rx_d = 1'b1;
          cnt_d = '0;
          target_d = words_for(2'h2, word0_q[DEP_FL_LSB +: DEP_FL_W]);
          st_d = DEP_ST_HD;
        end
      DEP_ST_HD:
        if (rd_hit && last)
        begin
          cnt_d = '0;
          if (word0_q[DEP_OUTPUT_PARAM_BIT])
          begin
            rx_d = 1'b1;
            target_d = DEP_OUTP_WORDS;
            st_d = DEP_ST_OUTP;
          end
          else
          begin
            tx_d = 1'b1;
            target_d = DEP_CFG_WORDS;
            st_d = DEP_ST_CFG;
          end
        end
        else if (rd_hit)
          cnt_d = cnt_q + 18'h00001;
      DEP_ST_OUTP:
        if (rd_hit && last)
        begin
          tx_d = 1'b1;
          cnt_d = '0;
          target_d = DEP_CFG_WORDS;
          st_d = DEP_ST_CFG;
        end
        else if (rd_hit)
          cnt_d = cnt_q + 18'h00001;
      default:
        st_d = DEP_ST_IDLE;
    endcase
  end

  // Two-cycle read: address to core, then data back to the DMA
  always_comb
  begin
    rd_pend_d = rd_hit | (i_dma_rd & ~rd_hit);
    rd_src_d = DEP_RSRC_BAD;
    if (rd_hit)
      rd_src_d = DEP_RSRC_CORE;
    else if (i_dma_rd & word0_hit)
      rd_src_d = DEP_RSRC_WORD0;
    raddr_d = rd_hit ? i_dma_addr[17:2] : raddr_q;
    rsel_d = rd_hit ? (st_q == DEP_ST_OUTP) : rsel_q;
    rvalid_d = rd_pend_q;
    rdata_d = rdata_q;
    if (rd_pend_q)
    begin
      unique case (rd_src_q)
        DEP_RSRC_CORE: rdata_d = i_core_rdata;
        DEP_RSRC_WORD0: rdata_d = word0_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q <= DEP_ST_IDLE;
      cnt_q <= '0;
      target_q <= DEP_CFG_WORDS;
      word0_q <= DEP_WORD0_RESET;
      tx_q <= 1'b0;
      rx_q <= 1'b0;
      start_q <= 1'b0;
      err_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_src_q <= DEP_RSRC_BAD;
      raddr_q <= '0;
      rsel_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end
    else if (i_ce)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      target_q <= target_d;
      word0_q <= word0_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      start_q <= start_d;
      err_q <= err_d;
      rd_pend_q <= rd_pend_d;
      rd_src_q <= rd_src_d;
      raddr_q <= raddr_d;
      rsel_q <= rsel_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_dma_wr_ready = strm.in_ready;
  assign o_dma_rvalid = rvalid_q;
  assign o_dma_rdata = rdata_q;
  assign o_access_err = err_q;
  assign o_transmit_sync_event = tx_q;
  assign o_receive_sync_event = rx_q;
  assign o_sym_valid = strm.out_valid;
  assign o_sym_kind = dep_kind_t'(strm.out_data[DATA_W +: 2]);
  assign o_sym_data = strm.out_data[DATA_W-1:0];
  assign o_decode_start = start_q;
  assign o_core_raddr = raddr_q;
  assign o_core_rsel = rsel_q;
  assign o_new_table_flag = word0_q[DEP_NEW_TABLE_BIT];
  assign o_output_param_flag = word0_q[DEP_OUTPUT_PARAM_BIT];
endmodule
`default_nettype wire

// ===== hw/dep_pkg.sv
// Constants and types shared by the decoder DMA event port
package dep_pkg;
  // Memory windows the DMA controller addresses
  localparam logic [31:0] DEP_CFG_BASE = 32'h5000_0000;
  localparam logic [31:0] DEP_SYM_BASE = 32'h5001_0000;
  localparam logic [31:0] DEP_ITL_BASE = 32'h5005_0000;
  localparam logic [31:0] DEP_HD_BASE = 32'h5006_0000;
  localparam logic [31:0] DEP_OUTP_ADDR = 32'h5000_0030;
  // DMA event line numbers
  localparam logic [4:0] DEP_TX_EVENT_LINE = 5'h1F;
  localparam logic [4:0] DEP_RX_EVENT_LINE = 5'h1E;
  // Transfer sizes in 32-bit words
  localparam logic [17:0] DEP_CFG_WORDS = 18'h00010;
  localparam logic [17:0] DEP_OUTP_WORDS = 18'h00003;
  // Fields of input_config_word0
  localparam int DEP_FL_LSB = 0;
  localparam int DEP_FL_W = 16;
  localparam int DEP_NEW_TABLE_BIT = 16;
  localparam int DEP_OUTPUT_PARAM_BIT = 17;
  localparam logic [31:0] DEP_WORD0_RESET = 32'h0000_0000;
  // Read pipeline source codes
  localparam logic [1:0] DEP_RSRC_CORE = 2'h0;
  localparam logic [1:0] DEP_RSRC_WORD0 = 2'h1;
  localparam logic [1:0] DEP_RSRC_BAD = 2'h2;

  typedef enum logic [1:0] {
    DEP_KIND_CFG = 2'h0,
    DEP_KIND_SYM = 2'h1,
    DEP_KIND_ITL = 2'h2
  } dep_kind_t;

  typedef enum logic [6:0] {
    DEP_ST_IDLE = 7'h01,
    DEP_ST_CFG = 7'h02,
    DEP_ST_SYM = 7'h04,
    DEP_ST_ITL = 7'h08,
    DEP_ST_DEC = 7'h10,
    DEP_ST_HD = 7'h20,
    DEP_ST_OUTP = 7'h40
  } dep_state_t;
endpackage

// ===== hw/dep_stream_if.sv
// Valid/ready carrier between the port logic and its two-entry buffer
`timescale 1ns/1ps
`default_nettype none
interface dep_stream_if #(parameter int W = 34);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport buffer (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
  modport owner (output in_valid, output in_data, output out_ready,
                 input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

// ===== sim/dep_dma_model.sv
// Behavioural host DMA controller on the port's bus side
`timescale 1ns/1ps
`default_nettype none
module dep_dma_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_wr,
  output logic o_rd,
  output logic [31:0] o_addr,
  output logic [31:0] o_wdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 32'hFFFF_FFFF;
    o_wdata = 32'h0;
  end
  // Held until ready is seen at a rising edge; returns on that edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge i_clk);
    o_rd = 1'b0;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    while (i_ready !== 1'b1)
      @(posedge i_clk);
  endtask
  // Reads never stall, one per cycle
  task automatic rd(input logic [31:0] a);
    @(negedge i_clk);
    o_wr = 1'b0;
    o_rd = 1'b1;
    o_addr = a;
    @(posedge i_clk);
  endtask
  // Released bus shows no stale word
  task automatic idle();
    @(negedge i_clk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask
endmodule
`default_nettype wire

// ===== sim/dep_event_port_props.sv
// Concurrent checks on the decoder DMA event port boundary
`timescale 1ns/1ps
`default_nettype none
module dep_event_port_props
  import dep_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_dma_wr,
  input wire logic i_dma_rd,
  input wire logic [31:0] i_dma_addr,
  input wire logic i_decode_done,
  input wire logic o_dma_wr_ready,
  input wire logic o_dma_rvalid,
  input wire logic o_access_err,
  input wire logic o_transmit_sync_event,
  input wire logic o_receive_sync_event,
  input wire logic o_sym_valid,
  input wire logic o_decode_start,
  input wire logic o_new_table_flag,
  input wire logic o_output_param_flag
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  logic take;
  assign take = i_dma_wr && o_dma_wr_ready;
  AST_TX_PULSE: assert property (o_transmit_sync_event |=> !o_transmit_sync_event)
    else $error("transmit event longer than a cycle");
  AST_RX_PULSE: assert property (o_receive_sync_event |=> !o_receive_sync_event)
    else $error("receive event longer than a cycle");
  AST_RX_CAUSE: assert property (o_receive_sync_event |-> $past(i_decode_done) || $past(i_dma_rd))
    else $error("receive event without done or read");
  AST_TX_QUIET: assert property (o_decode_start |-> !o_transmit_sync_event [*3])
    else $error("transmit event while decoding");
  AST_START_CAUSE: assert property (o_decode_start |-> $past(take))
    else $error("decode start without a taken word");
  AST_RD_ANSWER: assert property (i_dma_rd |-> ##2 o_dma_rvalid)
    else $error("read not answered in two cycles");
  AST_RVALID_CAUSE: assert property (o_dma_rvalid |-> $past(i_dma_rd, 2))
    else $error("read data without a request");
  AST_FLAGS_HOLD: assert property ($changed({o_new_table_flag, o_output_param_flag})
    |-> $past(take && i_dma_addr == DEP_CFG_BASE))
    else $error("flags changed without a word0 write");
  AST_READY_FULL: assert property (!o_dma_wr_ready |-> o_sym_valid)
    else $error("write refused with an empty buffer");
  AST_ERR_CAUSE: assert property (o_access_err |-> $past(i_dma_wr) || $past(i_dma_rd) || $past(i_dma_rd, 2))
    else $error("access error without an access");
endmodule
bind dep_event_port dep_event_port_props u_dep_event_port_props (.i_clk, .i_resetn, .i_dma_wr, .i_dma_rd,
  .i_dma_addr, .i_decode_done, .o_dma_wr_ready, .o_dma_rvalid, .o_access_err, .o_transmit_sync_event,
  .o_receive_sync_event, .o_sym_valid, .o_decode_start, .o_new_table_flag, .o_output_param_flag);
`default_nettype wire

// ===== sim/dep_event_port_test.sv
// Self-checking bench for the decoder DMA event port
`timescale 1ns/1ps
`default_nettype none
module dep_event_port_test;
  import dep_pkg::*;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t got %h exp %h", $time, g, e); end end
  logic i_clk, i_resetn, i_ce, i_sym_ready, i_decode_done, i_dma_wr, i_dma_rd;
  logic [31:0] i_dma_addr, i_dma_wdata, i_core_rdata, o_dma_rdata, o_sym_data, last_w0, r;
  logic o_dma_wr_ready, o_dma_rvalid, o_access_err, o_transmit_sync_event, o_receive_sync_event;
  logic o_sym_valid, o_decode_start, o_core_rsel, o_new_table_flag, o_output_param_flag;
  logic [15:0] o_core_raddr;
  logic [33:0] e;
  dep_kind_t o_sym_kind;
  logic [33:0] sq[$];
  logic [31:0] rq[$];
  int miscompares, samples_checked, n_tx, n_rx, n_err, n_tx0;
  dep_event_port u_dep_event_port (.i_clk, .i_resetn, .i_ce, .i_dma_wr, .i_dma_rd, .i_dma_addr,
    .i_dma_wdata, .o_dma_wr_ready, .o_dma_rvalid, .o_dma_rdata, .o_access_err, .o_transmit_sync_event,
    .o_receive_sync_event, .o_sym_valid, .o_sym_kind, .o_sym_data, .i_sym_ready, .o_decode_start,
    .i_decode_done, .o_core_raddr, .o_core_rsel, .i_core_rdata, .o_new_table_flag, .o_output_param_flag);
  dep_dma_model u_dep_dma_model (.i_clk(i_clk), .i_ready(o_dma_wr_ready), .o_wr(i_dma_wr),
    .o_rd(i_dma_rd), .o_addr(i_dma_addr), .o_wdata(i_dma_wdata));
  // Decoder core memory: word is a scramble of its address
  assign i_core_rdata = {o_core_raddr ^ 16'hA5A5, 15'h0, o_core_rsel};
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(negedge i_clk)
    i_sym_ready <= 1'($urandom_range(0, 1));
  always @(posedge i_clk)
  begin
    // A frozen port pops nothing, so the bench must not either
    if (i_ce === 1'b1 && o_sym_valid === 1'b1 && i_sym_ready === 1'b1)
    begin
      e = sq.pop_front();
      `CHK({o_sym_kind, o_sym_data}, e)
    end
    if (i_ce === 1'b1 && o_dma_rvalid === 1'b1)
    begin
      r = rq.pop_front();
      `CHK(o_dma_rdata, r)
    end
    n_tx += (o_transmit_sync_event === 1'b1);
    n_rx += (o_receive_sync_event === 1'b1);
    n_err += (o_access_err === 1'b1);
  end
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Even word counts keep every write transfer a multiple of eight bytes
  // Each array starts on a double-word boundary
  task automatic xfer(input logic [31:0] b, input int n, input dep_kind_t k);
    logic [31:0] d;
    for (int i = 0; i < n; i++)
    begin
      d = (k == DEP_KIND_CFG && i == 0) ? last_w0 : $urandom();
      sq.push_back({k, d});
      u_dep_dma_model.wr(b + 4 * i, d);
    end
  endtask
  task automatic rds(input logic [31:0] b, input int n, input logic s);
    for (int i = 0; i < n; i++)
    begin
      rq.push_back({(b[17:2] + 16'(i)) ^ 16'hA5A5, 15'h0, s});
      u_dep_dma_model.rd(b + 4 * i);
    end
    u_dep_dma_model.idle();
    repeat (3) @(negedge i_clk);
  endtask
  task automatic chan(input logic nt, input logic op);
    int fl, t0, r0;
    fl = $urandom_range(1, 130);
    last_w0 = {14'h0, op, nt, fl[15:0]};
    t0 = n_tx;
    r0 = n_rx;
    // Three to five arrays per channel, linked in order
    xfer(DEP_CFG_BASE, 16, DEP_KIND_CFG);
    xfer(DEP_SYM_BASE, 2 * ((fl + 1) / 2), DEP_KIND_SYM);
    if (nt)
      xfer(DEP_ITL_BASE, 2 * ((fl + 6) / 4), DEP_KIND_ITL);
    u_dep_dma_model.idle();
    `CHK(o_new_table_flag, nt)
    `CHK(o_output_param_flag, op)
    for (int i = 0; i < 300 && o_decode_start !== 1'b1; i++)
      @(negedge i_clk);
    `CHK(o_decode_start, 1'b1)
    repeat (4) @(negedge i_clk);
    `CHK(n_rx - r0, 0)
    // Clock enable low: a finished decode must not be reported yet
    i_ce = 1'b0;
    i_decode_done = 1'b1;
    repeat (4) @(negedge i_clk);
    `CHK(n_rx - r0, 0)
    i_ce = 1'b1;
    for (int i = 0; i < 300 && n_rx == r0; i++)
      @(negedge i_clk);
    rds(DEP_HD_BASE, 2 * ((fl + 63) / 64), 1'b0);
    `CHK(n_rx - r0, 1 + op)
    if (op)
      rds(DEP_OUTP_ADDR, 3, 1'b1);
    // No completion interrupt modelled; channel ends after its last receive array
    `CHK(n_tx - t0, 2 + nt)
    i_decode_done = 1'b0;
    $display("test channel nt=%0d op=%0d done", nt, op);
  endtask
  initial
  begin
    i_resetn = 1'b0;
    i_ce = 1'b1;
    i_decode_done = 1'b0;
    i_sym_ready = 1'b0;
    void'($urandom(36639));
    repeat (20) @(negedge i_clk);
    `CHK(o_dma_wr_ready, 1'b1)
    i_resetn = 1'b1;
    repeat (3) @(negedge i_clk);
    `CHK(n_tx, 1)
    $display("test reset done");
    for (int m = 0; m < 4; m++)
      chan(m[0], m[1]);
    n_err = 0;
    n_tx0 = n_tx;
    u_dep_dma_model.wr(DEP_SYM_BASE, 32'h0);
    rq.push_back(last_w0);
    rq.push_back(32'h0);
    u_dep_dma_model.rd(DEP_CFG_BASE);
    u_dep_dma_model.rd(DEP_ITL_BASE);
    u_dep_dma_model.idle();
    repeat (4) @(negedge i_clk);
    `CHK(n_err, 2)
    // Chain ended: the port waits in its config phase with no further transmit event
    `CHK(n_tx - n_tx0, 0)
    $display("test refused access done");
    end_sim();
  end
  initial
  begin
    #2000000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
